// file: interrupt_vector_lvd_control.sv
// Interrupt flag, mask, priority and vector sequencer with undervolt control
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module interrupt_vector_lvd_control (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic arst_n_in,
   // Register port
   input wire logic [3:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   output logic [31:0] reg_rdata_out,
   // Source events, one pulse per vector slot
   input wire logic [ivl_pkg::NUM_SLOTS-1:0] src_event_in,
   // Reset sources
   input wire logic wdog_timeout_in,
   input wire logic watchdog_enable_in,
   input wire logic pin_reset_in,
   input wire logic illegal_op_in,
   input wire logic icg_reset_in,
   // Supply comparators
   input wire logic supply_below_high_in,
   input wire logic supply_below_low_in,
   input wire logic warn_below_high_in,
   input wire logic warn_below_low_in,
   // Core side
   input wire logic instr_done_in,
   input wire logic [15:0] pc_in,
   input wire logic [7:0] x_in,
   input wire logic [7:0] a_in,
   input wire logic [7:0] ccr_in,
   input wire logic stop_req_in,
   input wire logic [1:0] stop_mode_in,
   input wire logic in_stop_in,
   output logic irq_req_out,
   output logic sys_reset_out,
   output logic push_valid_out,
   output logic [7:0] push_data_out,
   output logic [15:0] fetch_addr_out,
   output logic [15:0] vector_out,
   output logic vector_valid_out,
   output logic [4:0] vector_slot_out,
   output logic global_mask_out,
   output logic stop_grant_out,
   output logic undervolt_on_out,
   output logic irq_out
);
   import ivl_pkg::*;

   seq_state_t state;
   logic [4:0] slot;
   logic [2:0] push_cnt;
   logic [39:0] stack_buf;
   logic [31:0] flags;
   logic [31:0] lmask;
   logic [31:0] flag_set;
   logic [31:0] flag_clr;
   logic [31:0] req_vec;
   logic [5:0] power_ctrl_one;
   logic [1:0] power_ctrl_two;
   logic [7:0] reset_cause_reg;
   logic [ISTAT_W-1:0] istat;
   logic [ISTAT_W-1:0] imask;
   logic [ISTAT_W-1:0] istat_set;
   logic [5:0] vidx;
   logic [7:0] vec_mem [0:2*NUM_SLOTS-1];
   logic pick_found;
   logic [4:0] pick_idx;
   logic uv_detect;
   logic uv_reset_hold;
   logic supply_warning_flag;
   logic stop_refused;
   logic reset_trig;
   logic entry_done;
   logic swi_taken;
   logic wr_flags;
   logic wr_pwr1;

   // ----------------------------------------------------------------
   // Undervolt control and priority picker
   // ----------------------------------------------------------------
   undervolt_ctrl u_uv (
      .mclk_in(mclk_in),
      .arst_n_in(arst_n_in),
      .enable_in(power_ctrl_one[P1_EN]),
      .trip_select_in(power_ctrl_two[P2_TRIP]),
      .stop_enable_in(power_ctrl_one[P1_STOP_EN]),
      .reset_enable_in(power_ctrl_one[P1_RST_EN]),
      .irq_enable_in(power_ctrl_one[P1_IRQ_EN]),
      .warn_select_in(power_ctrl_two[P2_WARN_SEL]),
      .in_stop_in(in_stop_in),
      .below_high_in(supply_below_high_in),
      .below_low_in(supply_below_low_in),
      .warn_high_in(warn_below_high_in),
      .warn_low_in(warn_below_low_in),
      .stop_req_in(stop_req_in),
      .stop_mode_in(stop_mode_in),
      .detector_on_out(undervolt_on_out),
      .detect_out(uv_detect),
      .reset_hold_out(uv_reset_hold),
      .warning_out(supply_warning_flag),
      .stop_grant_out(stop_grant_out),
      .stop_refused_out(stop_refused)
   );

   prio_pick #(.N(NUM_SLOTS), .W(SLOT_W)) u_pick (
      .req_in(req_vec),
      .found_out(pick_found),
      .index_out(pick_idx)
   );

   // ----------------------------------------------------------------
   // Request qualification
   // ----------------------------------------------------------------
   // Software trap has no local enable and ignores the global mask
   always_comb begin
      req_vec = flags & (lmask | SWI_BIT) & ~RESET_BIT;
      if (global_mask_out) begin
         req_vec = req_vec & SWI_BIT;
      end
   end
   assign irq_req_out = pick_found && (state == SEQ_IDLE);

   // Any gated reset source restarts through the top vector
   assign reset_trig = (wdog_timeout_in && watchdog_enable_in) || pin_reset_in
                       || illegal_op_in || icg_reset_in || uv_reset_hold;
   assign entry_done = (state == SEQ_PUSH) && (push_cnt == PUSH_LAST) && !reset_trig;
   assign swi_taken = (state == SEQ_FETCH_LO) && (slot == SLOT_SWI) && !reset_trig;
   assign wr_flags = reg_write_in && (reg_addr_in == REG_FLAGS);
   assign wr_pwr1 = reg_write_in && (reg_addr_in == REG_PWR1);

   // ----------------------------------------------------------------
   // Source flags
   // ----------------------------------------------------------------
   // Unused slots are masked off so they can never pend
   assign flag_set = (src_event_in & SRC_EVENT_MASK) | ({31'h0, uv_detect} << SLOT_LVD);
   assign flag_clr = (wr_flags ? reg_wdata_in : 32'h0)
                     | ({31'h0, wr_pwr1 && reg_wdata_in[P1_ACK]} << SLOT_LVD)
                     | (swi_taken ? SWI_BIT : 32'h0);

   // Set beats a same-cycle acknowledge, so no event is lost
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         flags <= 32'h0;
      end else if (state == SEQ_HOLD) begin
         flags <= 32'h0;
      end else begin
         flags <= (flags & ~flag_clr) | flag_set;
      end
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   // Global mask: hardware set on reset and entry wins over software clear
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         global_mask_out <= 1'b1;
      end else if (state == SEQ_HOLD || entry_done) begin
         global_mask_out <= 1'b1;
      end else if (reg_write_in && reg_addr_in == REG_CORE) begin
         global_mask_out <= reg_wdata_in[0];
      end
   end

   // Local masks and vector table index
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         lmask <= 32'h0;
         vidx <= 6'h0;
         imask <= '0;
      end else if (reg_write_in) begin
         if (reg_addr_in == REG_LMASK) lmask <= reg_wdata_in;
         if (reg_addr_in == REG_VIDX) vidx <= reg_wdata_in[5:0];
         if (reg_addr_in == REG_IMASK) imask <= reg_wdata_in[ISTAT_W-1:0];
      end
   end

   // Control one returns to defaults on any reset; select bits survive all but the async reset
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         power_ctrl_one <= PWR1_RST;
         power_ctrl_two <= 2'h0;
      end else if (state == SEQ_HOLD) begin
         power_ctrl_one <= PWR1_RST;
      end else begin
         if (wr_pwr1) power_ctrl_one <= {reg_wdata_in[5:2], 2'h0};
         if (reg_write_in && reg_addr_in == REG_PWR2) power_ctrl_two <= reg_wdata_in[1:0];
      end
   end

   // Cause bits latched on the edge into reset, read only
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         reset_cause_reg <= CAUSE_POR_RST;
      end else if (reset_trig && state != SEQ_HOLD) begin
         reset_cause_reg <= 8'h0;
         reset_cause_reg[C_PIN] <= pin_reset_in;
         reset_cause_reg[C_WDOG] <= wdog_timeout_in && watchdog_enable_in;
         reset_cause_reg[C_ILOP] <= illegal_op_in;
         reset_cause_reg[C_ICG] <= icg_reset_in;
         reset_cause_reg[C_LVD] <= uv_reset_hold;
      end
   end

   // Vector table storage, software loaded byte by byte
   // Cleared on reset so the fetch right after reset never hands out unknowns
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         for (int i = 0; i < 2*NUM_SLOTS; i++) begin
            vec_mem[i] <= 8'h00;
         end
      end else if (reg_write_in && reg_addr_in == REG_VDATA) begin
         vec_mem[vidx] <= reg_wdata_in[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Block interrupt status, cleared by reading it
   // ----------------------------------------------------------------
   assign istat_set = {uv_detect, stop_refused, vector_valid_out};
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         istat <= '0;
      end else if (reg_read_in && reg_addr_in == REG_ISTAT) begin
         istat <= istat_set;
      end else begin
         istat <= istat | istat_set;
      end
   end
   assign irq_out = |(istat & imask);

   // ----------------------------------------------------------------
   // Read port, data one cycle after the strobe
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         reg_rdata_out <= 32'h0;
      end else if (reg_read_in) begin
         unique case (reg_addr_in)
            REG_FLAGS: reg_rdata_out <= flags;
            REG_LMASK: reg_rdata_out <= lmask;
            REG_CORE: reg_rdata_out <= {31'h0, global_mask_out};
            REG_PWR1: reg_rdata_out <= {26'h0, power_ctrl_one[5:2], 1'b0, flags[SLOT_LVD]};
            REG_PWR2: reg_rdata_out <= {29'h0, supply_warning_flag, power_ctrl_two};
            REG_CAUSE: reg_rdata_out <= {24'h0, reset_cause_reg};
            REG_ISTAT: reg_rdata_out <= {29'h0, istat};
            REG_IMASK: reg_rdata_out <= {29'h0, imask};
            REG_VIDX: reg_rdata_out <= {26'h0, vidx};
            REG_VDATA: reg_rdata_out <= {24'h0, vec_mem[vidx]};
            default: reg_rdata_out <= 32'h0;
         endcase
      end else begin
         reg_rdata_out <= 32'h0;
      end
   end

   // ----------------------------------------------------------------
   // Entry sequencer: hold, stack, fetch
   // ----------------------------------------------------------------
   // The whole frame is captured at once so a moving core cannot tear it
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state <= SEQ_HOLD;
         sys_reset_out <= 1'b1;
         slot <= 5'h0;
         push_cnt <= 3'h0;
         stack_buf <= 40'h0;
         push_valid_out <= 1'b0;
         push_data_out <= 8'h0;
         fetch_addr_out <= 16'h0;
         vector_out <= 16'h0;
         vector_valid_out <= 1'b0;
         vector_slot_out <= 5'h0;
      end else begin
         push_valid_out <= 1'b0;
         vector_valid_out <= 1'b0;
         if (reset_trig) begin
            state <= SEQ_HOLD;
            sys_reset_out <= 1'b1;
         end else begin
            unique case (state)
               SEQ_HOLD: begin
                  sys_reset_out <= 1'b0;
                  slot <= SLOT_RESET;
                  state <= SEQ_FETCH_HI;
               end
               SEQ_IDLE: begin
                  if (pick_found && instr_done_in) begin
                     slot <= pick_idx;
                     stack_buf <= {ccr_in, a_in, x_in, pc_in[15:8], pc_in[7:0]};
                     push_cnt <= 3'h0;
                     state <= SEQ_PUSH;
                  end
               end
               SEQ_PUSH: begin
                  push_valid_out <= 1'b1;
                  push_data_out <= stack_buf[8*push_cnt +: 8];
                  push_cnt <= push_cnt + 3'h1;
                  if (push_cnt == PUSH_LAST) state <= SEQ_FETCH_HI;
               end
               SEQ_FETCH_HI: begin
                  fetch_addr_out <= VEC_BASE + {10'h0, slot, 1'b0};
                  state <= SEQ_FETCH_LO;
               end
               SEQ_FETCH_LO: begin
                  fetch_addr_out <= VEC_BASE + {10'h0, slot, 1'b1};
                  vector_out <= {vec_mem[{slot, 1'b0}], vec_mem[{slot, 1'b1}]};
                  vector_valid_out <= 1'b1;
                  vector_slot_out <= slot;
                  state <= SEQ_IDLE;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_prio;
      @(posedge mclk_in) disable iff (!arst_n_in) pick_found |-> ((req_vec >> pick_idx) == 32'h1);
   endproperty
   a_prio: assert property (p_prio) else $error("winner is not the top request");

   property p_bytes;
      @(posedge mclk_in) disable iff (!arst_n_in)
         (vector_valid_out && !$past(reg_write_in))
         |-> vector_out == {vec_mem[{vector_slot_out, 1'b0}], vec_mem[{vector_slot_out, 1'b1}]};
   endproperty
   a_bytes: assert property (p_bytes) else $error("vector bytes out of order");

   property p_mask;
      @(posedge mclk_in) disable iff (!arst_n_in) irq_req_out |-> |(flags & (lmask | SWI_BIT));
   endproperty
   a_mask: assert property (p_mask) else $error("request without unmasked flag");

   property p_stack;
      @(posedge mclk_in) disable iff (!arst_n_in || reset_trig)
         $rose(push_valid_out) |-> push_data_out == $past(stack_buf[7:0]) ##0 push_valid_out[*5] ##1
         (!push_valid_out && global_mask_out);
   endproperty
   a_stack: assert property (p_stack) else $error("stack frame wrong");

   property p_reset_src;
      @(posedge mclk_in) disable iff (!arst_n_in) pin_reset_in |=> sys_reset_out ##1 (state == SEQ_HOLD || slot == SLOT_RESET);
   endproperty
   a_reset_src: assert property (p_reset_src) else $error("pin reset not taken");

   property p_unused;
      @(posedge mclk_in) disable iff (!arst_n_in) flags[SLOT_RTI-1:0] == 6'h0;
   endproperty
   a_unused: assert property (p_unused) else $error("unused slot flagged");

   property p_stop;
      @(posedge mclk_in) disable iff (!arst_n_in) stop_refused |-> !stop_grant_out ##1 istat[ST_STOP];
   endproperty
   a_stop: assert property (p_stop) else $error("deep stop not refused");

   property p_uv_flag;
      @(posedge mclk_in) disable iff (!arst_n_in) (uv_detect && state != SEQ_HOLD) |=> flags[SLOT_LVD];
   endproperty
   a_uv_flag: assert property (p_uv_flag) else $error("detect flag not set");

   property p_flag_hold;
      @(posedge mclk_in) disable iff (!arst_n_in)
         $past(state) != SEQ_HOLD |-> ((($past(flags) & ~flags) & ~$past(flag_clr)) == 32'h0);
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without ack");

   property p_gmask;
      @(posedge mclk_in) disable iff (!arst_n_in) sys_reset_out |=> global_mask_out;
   endproperty
   a_gmask: assert property (p_gmask) else $error("global mask clear after reset");

   c_entry: cover property (@(posedge mclk_in) disable iff (!arst_n_in) $rose(push_valid_out));
   c_swi: cover property (@(posedge mclk_in) disable iff (!arst_n_in) vector_valid_out && vector_slot_out == SLOT_SWI);
   c_uvrst: cover property (@(posedge mclk_in) disable iff (!arst_n_in) uv_reset_hold && !$past(uv_reset_hold));
endmodule

// file: ivl_pkg.sv
// Constants and types shared by the interrupt vector and undervolt control block
package ivl_pkg;

   // ----------------------------------------------------------------
   // Vector table layout
   // ----------------------------------------------------------------
   localparam int NUM_SLOTS = 32;
   localparam int SLOT_W = 5;
   localparam logic [15:0] VEC_BASE = 16'hFFC0;
   localparam logic [4:0] SLOT_RESET = 5'h1F;
   localparam logic [4:0] SLOT_SWI = 5'h1E;
   localparam logic [4:0] SLOT_IRQ = 5'h1D;
   localparam logic [4:0] SLOT_LVD = 5'h1C;
   localparam logic [4:0] SLOT_RTI = 5'h06;
   // Slots 0..5 unused, 28 and 31 fed internally, rest from sources
   localparam logic [31:0] SRC_EVENT_MASK = 32'h6FFF_FFC0;
   localparam logic [31:0] SWI_BIT = 32'h4000_0000;
   localparam logic [31:0] RESET_BIT = 32'h8000_0000;
   localparam logic [2:0] PUSH_LAST = 3'h4;

   // ----------------------------------------------------------------
   // Register offsets and fields
   // ----------------------------------------------------------------
   localparam logic [3:0] REG_FLAGS = 4'h0;
   localparam logic [3:0] REG_LMASK = 4'h1;
   localparam logic [3:0] REG_CORE = 4'h2;
   localparam logic [3:0] REG_PWR1 = 4'h3;
   localparam logic [3:0] REG_PWR2 = 4'h4;
   localparam logic [3:0] REG_CAUSE = 4'h5;
   localparam logic [3:0] REG_ISTAT = 4'h6;
   localparam logic [3:0] REG_IMASK = 4'h7;
   localparam logic [3:0] REG_VIDX = 4'h8;
   localparam logic [3:0] REG_VDATA = 4'h9;
   localparam int P1_FLAG = 0;
   localparam int P1_ACK = 1;
   localparam int P1_IRQ_EN = 2;
   localparam int P1_RST_EN = 3;
   localparam int P1_STOP_EN = 4;
   localparam int P1_EN = 5;
   localparam int P2_TRIP = 0;
   localparam int P2_WARN_SEL = 1;
   localparam int P2_WARN = 2;
   localparam int C_POR = 7;
   localparam int C_PIN = 6;
   localparam int C_WDOG = 5;
   localparam int C_ILOP = 4;
   localparam int C_ICG = 2;
   localparam int C_LVD = 1;
   localparam logic [5:0] PWR1_RST = 6'h28;
   localparam logic [7:0] CAUSE_POR_RST = 8'h82;
   localparam int ST_VEC = 0;
   localparam int ST_STOP = 1;
   localparam int ST_UV = 2;
   localparam int ISTAT_W = 3;

   // ----------------------------------------------------------------
   // Stop modes and sequencer states
   // ----------------------------------------------------------------
   localparam logic [1:0] STOP1 = 2'h1;
   localparam logic [1:0] STOP2 = 2'h2;
   typedef enum logic [2:0] {SEQ_HOLD, SEQ_IDLE, SEQ_PUSH, SEQ_FETCH_HI, SEQ_FETCH_LO} seq_state_t;

endpackage

// file: prio_pick.sv
// Fixed priority picker: the highest requesting index wins
`timescale 1ns/1ps
module prio_pick #(
   parameter int N = 32,
   parameter int W = 5
) (
   // Requests
   input wire logic [N-1:0] req_in,
   // Winner
   output logic found_out,
   output logic [W-1:0] index_out
);
   // Ascending scan, so a later (higher) index overrides a lower one
   always_comb begin
      found_out = 1'b0;
      index_out = '0;
      for (int i = 0; i < N; i++) begin
         if (req_in[i]) begin
            found_out = 1'b1;
            index_out = W'(i);
         end
      end
   end
endmodule

// file: undervolt_ctrl.sv
// Digital control of the undervolt detector, warning and stop gating
`timescale 1ns/1ps
module undervolt_ctrl
   import ivl_pkg::*;
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic arst_n_in,
   // Control bits
   input wire logic enable_in,
   input wire logic trip_select_in,
   input wire logic stop_enable_in,
   input wire logic reset_enable_in,
   input wire logic irq_enable_in,
   input wire logic warn_select_in,
   input wire logic in_stop_in,
   // Comparator levels
   input wire logic below_high_in,
   input wire logic below_low_in,
   input wire logic warn_high_in,
   input wire logic warn_low_in,
   // Stop requests
   input wire logic stop_req_in,
   input wire logic [1:0] stop_mode_in,
   // Results
   output logic detector_on_out,
   output logic detect_out,
   output logic reset_hold_out,
   output logic warning_out,
   output logic stop_grant_out,
   output logic stop_refused_out
);
   logic below;
   logic tripped;
   logic tripped_q;
   logic por_hold;
   logic uv_hold;

   // Detector powered only when enabled and not dropped by stop
   assign detector_on_out = enable_in && (!in_stop_in || stop_enable_in);
   assign below = trip_select_in ? below_high_in : below_low_in;
   assign tripped = detector_on_out && below;
   assign reset_hold_out = por_hold || uv_hold;

   // Power-on hold lasts until supply passes the high level
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         por_hold <= 1'b1;
      end else if (!below_high_in) begin
         por_hold <= 1'b0;
      end
   end

   // Undervolt reset hold releases on the selected level only
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         uv_hold <= 1'b0;
      end else if (tripped && reset_enable_in) begin
         uv_hold <= 1'b1;
      end else if (!below) begin
         uv_hold <= 1'b0;
      end
   end

   // Interrupt mode fires once per entry into the low region
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         tripped_q <= 1'b0;
         detect_out <= 1'b0;
      end else begin
         tripped_q <= tripped;
         detect_out <= tripped && !tripped_q && irq_enable_in && !reset_enable_in;
      end
   end

   // Warning is a status level only, it never reaches the picker
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         warning_out <= 1'b0;
      end else begin
         warning_out <= enable_in && (warn_select_in ? warn_high_in : warn_low_in);
      end
   end

   // Keeping the detector alive in stop costs the deep stop modes
   assign stop_refused_out = stop_req_in && enable_in && stop_enable_in
                             && (stop_mode_in == STOP1 || stop_mode_in == STOP2);
   assign stop_grant_out = stop_req_in && !stop_refused_out;
endmodule

// file: core_model.sv
// Behavioural processor core feeding the interrupt block
`timescale 1ns/1ps
module core_model (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic arst_n_in,
   // Core state
   output logic instr_done_out,
   output logic [15:0] pc_out,
   output logic [7:0] x_out,
   output logic [7:0] a_out,
   output logic [7:0] ccr_out
);
   // Boundary every other cycle, so entry must wait for it
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         instr_done_out <= 1'b0;
      end else begin
         instr_done_out <= ~instr_done_out;
      end
   end
   assign pc_out = 16'h1234;
   assign x_out = 8'h56;
   assign a_out = 8'h78;
   assign ccr_out = 8'h60;
endmodule

// file: testbench.sv
// Self-checking bench for the interrupt vector and undervolt block
`timescale 1ns/1ps
`define CHK(v, e) begin cmp_count++; if ((v) !== (e)) begin miscompares++; \
   $display("Error at %0t: got %0h expected %0h", $time, v, e); end end
module testbench;
   import ivl_pkg::*;
   logic mclk_in = 0, arst_n_in = 0, wr = 0, rd = 0, done, stop_req = 0, below = 0;
   logic pin_rst = 0, in_stop = 0, uv_on;
   logic [3:0] addr = 0;
   logic [31:0] wdata = 0, rdata, ev = 0, d;
   logic [15:0] pc, vec, faddr;
   logic [7:0] x, a, condition_code_reg, pd, first;
   logic irq_req, sys_rst, pv, vv, gmask, grant, irq;
   logic [4:0] slot;
   logic [1:0] mode = 0;
   int miscompares = 0, cmp_count = 0, n;
   always #5 mclk_in = ~mclk_in;
   core_model core_model_i (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .instr_done_out(done),
      .pc_out(pc), .x_out(x), .a_out(a), .ccr_out(condition_code_reg));
   interrupt_vector_lvd_control interrupt_vector_lvd_control_i (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata),
      .src_event_in(ev), .wdog_timeout_in(1'b0), .watchdog_enable_in(1'b1), .pin_reset_in(pin_rst),
      .illegal_op_in(1'b0), .icg_reset_in(1'b0), .supply_below_high_in(below), .supply_below_low_in(below),
      .warn_below_high_in(below), .warn_below_low_in(1'b0), .instr_done_in(done), .pc_in(pc), .x_in(x),
      .a_in(a), .ccr_in(condition_code_reg), .stop_req_in(stop_req), .stop_mode_in(mode), .in_stop_in(in_stop),
      .irq_req_out(irq_req), .sys_reset_out(sys_rst), .push_valid_out(pv), .push_data_out(pd),
      .fetch_addr_out(faddr), .vector_out(vec), .vector_valid_out(vv), .vector_slot_out(slot),
      .global_mask_out(gmask), .stop_grant_out(grant), .undervolt_on_out(uv_on), .irq_out(irq));
   // Register port cycles
   task automatic wreg(input logic [3:0] ad, input logic [31:0] da);
      @(posedge mclk_in) begin addr <= ad; wdata <= da; wr <= 1'b1; end
      @(posedge mclk_in) wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] ad, output logic [31:0] da);
      @(posedge mclk_in) begin addr <= ad; rd <= 1'b1; end
      @(posedge mclk_in) rd <= 1'b0;
      #1 da = rdata;
   endtask
   task automatic complete_run;
      $display("errors %0d checks %0d", miscompares, cmp_count);
      if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Watchdog: whole sequence needs well under 1000 cycles
   initial begin
      #20us miscompares++;
      complete_run();
   end
   initial begin
      repeat (4) @(posedge mclk_in);
      arst_n_in <= 1'b1;
      `CHK(gmask, 1'b1)
      repeat (6) @(posedge mclk_in);
      #1;
      `CHK(sys_rst, 1'b0)
      rreg(REG_CAUSE, d); `CHK(d, 32'h82)
      rreg(REG_PWR1, d); `CHK(d, 32'h28)
      rreg(4'hF, d); `CHK(d, 32'h0)
      // Slot 9 vector: high byte at the even index, low byte at the odd one
      wreg(REG_VIDX, 32'h12);
      wreg(REG_VDATA, 32'hAB);
      wreg(REG_VIDX, 32'h13);
      wreg(REG_VDATA, 32'hCD);
      // Two unmasked events plus one masked and one on a sourceless slot; higher slot must win
      wreg(REG_LMASK, 32'h0000_0280);
      wreg(REG_CORE, 32'h0);
      @(posedge mclk_in) ev <= 32'h0000_0A81;
      @(posedge mclk_in) ev <= 32'h0;
      n = 0;
      for (int i = 0; i < 40 && !vv; i++) begin
         @(posedge mclk_in); #1;
         if (pv && n++ == 0) first = pd;
      end
      `CHK(first, 8'h34)
      `CHK(n, 5)
      `CHK(slot, 5'h09)
      `CHK(vec, 16'hABCD)
      `CHK(faddr, 16'hFFD3)
      `CHK(gmask, 1'b1)
      rreg(REG_FLAGS, d); `CHK(d, 32'h0000_0A80)
      // Stop with detector kept alive refuses deep modes
      wreg(REG_PWR1, 32'h30);
      for (int m = 1; m <= 3; m++) begin
         @(posedge mclk_in) begin stop_req <= 1'b1; mode <= 2'(m); end
         #1 `CHK(grant, 1'(m == 3))
         @(posedge mclk_in) stop_req <= 1'b0;
      end
      wreg(REG_IMASK, 32'h2);
      #1 `CHK(irq, 1'b1)
      rreg(REG_ISTAT, d); `CHK(d[1], 1'b1)
      #1 `CHK(irq, 1'b0)
      // Interrupt mode detection sets the undervolt flag
      wreg(REG_PWR1, 32'h24);
      below <= 1'b1;
      repeat (3) @(posedge mclk_in);
      rreg(REG_PWR1, d); `CHK(d[0], 1'b1)
      `CHK(sys_rst, 1'b0)
      // Warning follows its own select and raises no request
      wreg(REG_PWR2, 32'h2);
      rreg(REG_PWR2, d); `CHK(d, 32'h6)
      `CHK(irq_req, 1'b0)
      // Detector drops in stop unless kept alive
      @(posedge mclk_in) begin in_stop <= 1'b1; below <= 1'b0; end
      #1 `CHK(uv_on, 1'b0)
      // Mid-run pin reset: flags and control one restart, selects survive
      @(posedge mclk_in) begin in_stop <= 1'b0; pin_rst <= 1'b1; end
      @(posedge mclk_in) pin_rst <= 1'b0;
      #1 `CHK(sys_rst, 1'b1)
      repeat (3) @(posedge mclk_in);
      rreg(REG_CAUSE, d); `CHK(d, 32'h40)
      `CHK(slot, 5'h1F)
      `CHK(gmask, 1'b1)
      rreg(REG_FLAGS, d); `CHK(d, 32'h0)
      rreg(REG_PWR1, d); `CHK(d, 32'h28)
      rreg(REG_PWR2, d); `CHK(d, 32'h2)
      complete_run();
   end
endmodule
